//--- core/sfe_pkg.sv
// constants and carrier types shared by the serial flash erase controller
package sfe_pkg;

  // ----------------------------------------------------------------
  // serial command codes (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'hA1;
  localparam logic [7:0] OP_ERASE_SMALL     = 8'hA2;
  localparam logic [7:0] OP_ERASE_LARGE     = 8'hA3;
  localparam logic [7:0] OP_ERASE_WHOLE     = 8'hA4;
  localparam logic [7:0] OP_ERASE_PERSIST   = 8'hA5;
  localparam logic [7:0] OP_CHECK_RESULT    = 8'hA6;
  localparam logic [7:0] OP_ERASE_COUNT     = 8'hA7;
  localparam logic [7:0] OP_READ_STATUS_ONE = 8'hA8;
  localparam logic [7:0] OP_READ_STATUS_TWO = 8'hA9;
  localparam logic [7:0] OP_READ_ANY_REG    = 8'hAA;
  localparam logic [7:0] OP_SUSPEND         = 8'hAB;
  localparam logic [7:0] OP_RESUME          = 8'hAC;

  // ----------------------------------------------------------------
  // frame lengths and address layout
  // ----------------------------------------------------------------
  localparam logic [5:0] BITS_CMD   = 6'h08;
  localparam logic [5:0] BITS_ADDR  = 6'h28;
  localparam int         LARGE_LSB  = 18;
  localparam int         SMALL_LSB  = 12;
  localparam int         OVERLAY_BIT = 17;

  // ----------------------------------------------------------------
  // APB register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_PROTECT = 8'h04;
  localparam logic [7:0] OFF_DYNPROT = 8'h08;
  localparam logic [7:0] OFF_PERSIST = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_LGDIRTY = 8'h14;
  localparam logic [7:0] OFF_SMDIRTY = 8'h18;
  localparam logic [7:0] OFF_COUNT   = 8'h1C;
  localparam int CFG_BP_LSB  = 0;
  localparam int CFG_UNIFORM = 3;
  localparam int CFG_BLANK   = 4;
  localparam int CFG_TOP     = 5;
  localparam int PROT_PERM   = 0;
  localparam int PROT_GUARD  = 3;
  localparam int PROT_LOCK   = 8;
  localparam int SR1_BUSY    = 0;
  localparam int SR1_WEL     = 1;
  localparam int SR1_FAIL    = 5;
  localparam int SR2_SUSP    = 1;
  localparam int SR2_RESULT  = 2;
  localparam int CNT_CORRUPT = 23;
  localparam logic [31:0] CONFIG_RESET  = 32'h0000_0000;
  localparam logic [31:0] PROTECT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  op;
    logic [31:0] addr;
  } sfe_cmd_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_WHOLE, ST_PERSIST, ST_CHECK, ST_COUNT,
                            ST_SUSP} sfe_state_t;

endpackage : sfe_pkg

//--- core/sfe_erase_ctrl.sv
// serial flash erase controller: SPI command port, erase engine, APB view
`timescale 1ns/1ns
// Summary of operation
// - erase needs prior write-latch command
// - erase runs only with latch; clears it
// - busy flag high during self-timed erase
// - erase errors reported in status bit 5
// - protected target skipped, fail flag set
// - erase starts at chip select rise
// - small erase fills 4KB; ignored if uniform
// - small erase outside region aborts silently
// - hybrid small sectors overlay top or bottom
// - large erase spares overlaid small sectors
// - uniform mode erases full large sectors
// - blank precheck aborts erase on blank sector
// - whole erase only with protect bits zero
// - whole erase skips protected sectors silently
// - persist erase aborts when guarded or locked
// - result check writes status two bit 2
// - result check needs no latch; busy shown
// - count command loads 23-bit count, busy shown
// - count bit 23 flags corrupted and reset
// - suspend ignored during whole erase
// - status two bit 1 shows suspended erase
module sfe_erase_ctrl #(
  parameter int NSEC          = 16,
  parameter int SMALL_CYC     = 20,
  parameter int LARGE_CYC     = 40,
  parameter int WHOLE_CYC     = 80,
  parameter int PERSIST_CYC   = 20,
  parameter int PRECHECK_CYC  = 8,
  parameter int CHECK_CYC     = 10,
  parameter int COUNT_CYC     = 10
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        spiClk,
  input  wire logic        spiCsN,
  input  wire logic        spiMosi,
  output logic             spiMiso,
  output logic             spiMisoOe,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam int SW = $clog2(NSEC);

  // ----------------------------------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------------------------------
  logic [2:0]  sclkSync;
  logic [2:0]  csSync;
  logic [2:0]  mosiSync;
  logic        sclkLvl;
  logic        csLvl;
  logic        sclkRise;
  logic        sclkFall;
  logic        csRise;
  logic        csFall;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkSync <= 3'h0;
      csSync   <= 3'h7;
      mosiSync <= 3'h0;
    end
    else
    begin
      sclkSync <= {sclkSync[1:0], spiClk};
      csSync   <= {csSync[1:0], spiCsN};
      mosiSync <= {mosiSync[1:0], spiMosi};
    end
  end

  assign sclkRise = (sclkSync[1] == sclkSync[2]) && sclkSync[2] && !sclkLvl;
  assign sclkFall = (sclkSync[1] == sclkSync[2]) && !sclkSync[2] && sclkLvl;
  assign csRise   = (csSync[1] == csSync[2]) && csSync[2] && !csLvl;
  assign csFall   = (csSync[1] == csSync[2]) && !csSync[2] && csLvl;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkLvl <= 1'b0;
      csLvl   <= 1'b1;
    end
    else
    begin
      if (sclkSync[1] == sclkSync[2])
        sclkLvl <= sclkSync[2];
      if (csSync[1] == csSync[2])
        csLvl <= csSync[2];
    end
  end

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  logic [39:0]       shiftIn;
  logic [5:0]        bitCnt;
  sfe_pkg::sfe_cmd_t cmdNow;
  logic              frameShort;
  logic              frameLong;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shiftIn <= 40'h00_0000_0000;
      bitCnt  <= 6'h00;
    end
    else if (csFall)
      bitCnt <= 6'h00;
    else if (sclkRise && !csLvl)
    begin
      shiftIn <= {shiftIn[38:0], mosiSync[2]};
      if (bitCnt != 6'h3F)
        bitCnt <= bitCnt + 6'h01;
    end
  end

  assign frameShort  = (bitCnt == sfe_pkg::BITS_CMD);
  assign frameLong   = (bitCnt == sfe_pkg::BITS_ADDR);
  assign cmdNow = frameLong ? shiftIn : {shiftIn[7:0], 32'h0000_0000};

  // ----------------------------------------------------------------
  // configuration registers and sector state
  // ----------------------------------------------------------------
  logic [31:0]      cfgReg;
  logic [31:0]      protReg;
  logic [NSEC-1:0]  dynProt;
  logic [NSEC-1:0]  persistBits;
  logic [NSEC-1:0]  lgDirty;
  logic [NSEC-1:0]  lgDone;
  logic [31:0]      smDirty;
  logic [31:0]      smDone;
  logic [22:0]      eraseCount [NSEC];
  logic [NSEC-1:0]  countCorrupt;
  logic [2:0]       blockProt;
  logic             uniform;
  logic [SW-1:0]    ovIdx;
  logic [SW-1:0]    lgIdx;
  logic [4:0]       smIdx;
  logic             inSmall;
  logic             protHit;
  logic             apbWr;
  logic [NSEC-1:0]  lgMark;
  logic [31:0]      smMark;

  assign blockProt = cfgReg[sfe_pkg::CFG_BP_LSB +: 3];
  assign uniform   = cfgReg[sfe_pkg::CFG_UNIFORM];
  assign ovIdx     = cfgReg[sfe_pkg::CFG_TOP] ? SW'(NSEC - 1) : '0;
  assign lgIdx     = cmdNow.addr[sfe_pkg::LARGE_LSB +: SW];
  assign smIdx     = cmdNow.addr[sfe_pkg::SMALL_LSB +: 5];
  // small sectors fill one half of the overlaid large sector
  assign inSmall   = !uniform && (lgIdx == ovIdx)
                     && (cmdNow.addr[sfe_pkg::OVERLAY_BIT] == cfgReg[sfe_pkg::CFG_TOP]);
  assign apbWr     = psel && penable && pwrite;
  // a marking write wins over an erase that ends in the same cycle
  assign lgMark    = (apbWr && paddr == sfe_pkg::OFF_LGDIRTY) ? pwdata[NSEC-1:0] : '0;
  assign smMark    = (apbWr && paddr == sfe_pkg::OFF_SMDIRTY) ? pwdata : 32'h0000_0000;

  // block-protect bits guard the top 2^(bp-1) large sectors
  function automatic logic bp_hit(input logic [2:0] bp, input logic [SW-1:0] idx);
    int span;
    span = (bp == 3'h0) ? 0 : (1 << (bp - 3'h1));
    return (int'(idx) >= NSEC - span);
  endfunction : bp_hit

  assign protHit = bp_hit(blockProt, lgIdx) || dynProt[lgIdx] || !persistBits[lgIdx];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfgReg  <= sfe_pkg::CONFIG_RESET;
      protReg <= sfe_pkg::PROTECT_RESET;
    end
    else if (apbWr && paddr == sfe_pkg::OFF_CONFIG)
      cfgReg <= pwdata;
    else if (apbWr && paddr == sfe_pkg::OFF_PROTECT)
      protReg <= pwdata;
  end

  // ----------------------------------------------------------------
  // erase engine
  // ----------------------------------------------------------------
  sfe_pkg::sfe_state_t state;
  logic [15:0]   timer;
  logic [SW-1:0] tgtLg;
  logic [4:0]    tgtSm;
  logic          tgtSmall;
  logic          skipErase;
  logic          wel;
  logic          failFlag;
  logic          suspended;
  logic          checkRes;
  logic [23:0]   countReg;
  logic          busy;
  logic          go;
  logic          timerDone;

  assign busy      = (state != sfe_pkg::ST_IDLE) && (state != sfe_pkg::ST_SUSP);
  assign go        = csRise && (frameShort || frameLong);
  assign timerDone = (timer == 16'h0000);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state        <= sfe_pkg::ST_IDLE;
      timer        <= 16'h0000;
      tgtLg        <= '0;
      tgtSm        <= 5'h00;
      tgtSmall     <= 1'b0;
      skipErase    <= 1'b0;
      wel          <= 1'b0;
      failFlag     <= 1'b0;
      suspended    <= 1'b0;
      checkRes     <= 1'b0;
      countReg     <= 24'h00_0000;
      dynProt      <= '0;
      persistBits  <= '1;
      lgDirty      <= '0;
      lgDone       <= '1;
      smDirty      <= 32'h0000_0000;
      smDone       <= 32'hFFFF_FFFF;
      countCorrupt <= '0;
      for (int i = 0; i < NSEC; i++)
        eraseCount[i] <= 23'h00_0000;
    end
    else
    begin
      // software stands in for programming: it marks sectors as written
      if (apbWr && paddr == sfe_pkg::OFF_DYNPROT)
        dynProt <= pwdata[NSEC-1:0];
      if (apbWr && paddr == sfe_pkg::OFF_PERSIST)
        persistBits <= pwdata[NSEC-1:0];
      if (apbWr && paddr == sfe_pkg::OFF_LGDIRTY)
        lgDirty <= lgDirty | pwdata[NSEC-1:0];
      if (apbWr && paddr == sfe_pkg::OFF_SMDIRTY)
        smDirty <= smDirty | pwdata;
      if (!timerDone && state != sfe_pkg::ST_SUSP)
        timer <= timer - 16'h0001;
      case (state)
        sfe_pkg::ST_IDLE:
        begin
          if (go)
          begin
            tgtLg    <= lgIdx;
            tgtSm    <= smIdx;
            tgtSmall <= inSmall;
            if (frameShort && cmdNow.op == sfe_pkg::OP_SET_WRITE_LATCH)
              wel <= 1'b1;
            else if (frameLong && wel && cmdNow.op == sfe_pkg::OP_ERASE_SMALL && !uniform)
            begin
              if (!inSmall)
                wel <= 1'b0;
              else if (protHit)
              begin
                failFlag <= 1'b1;
                wel      <= 1'b0;
              end
              else
              begin
                failFlag  <= 1'b0;
                smDone[smIdx] <= 1'b0;
                skipErase <= cfgReg[sfe_pkg::CFG_BLANK] && !smDirty[smIdx];
                timer     <= (cfgReg[sfe_pkg::CFG_BLANK] && !smDirty[smIdx])
                             ? 16'(PRECHECK_CYC - 1) : 16'(SMALL_CYC - 1);
                state     <= sfe_pkg::ST_ERASE;
              end
            end
            else if (frameLong && wel && cmdNow.op == sfe_pkg::OP_ERASE_LARGE)
            begin
              if (protHit)
              begin
                failFlag <= 1'b1;
                wel      <= 1'b0;
              end
              else
              begin
                failFlag       <= 1'b0;
                tgtSmall       <= 1'b0;
                lgDone[lgIdx]  <= 1'b0;
                skipErase      <= cfgReg[sfe_pkg::CFG_BLANK] && !lgDirty[lgIdx];
                timer          <= (cfgReg[sfe_pkg::CFG_BLANK] && !lgDirty[lgIdx])
                                  ? 16'(PRECHECK_CYC - 1) : 16'(LARGE_CYC - 1);
                state          <= sfe_pkg::ST_ERASE;
              end
            end
            else if (frameShort && wel && cmdNow.op == sfe_pkg::OP_ERASE_WHOLE)
            begin
              if (blockProt != 3'h0)
              begin
                failFlag <= 1'b1;
                wel      <= 1'b0;
              end
              else
              begin
                failFlag <= 1'b0;
                timer    <= 16'(WHOLE_CYC - 1);
                state    <= sfe_pkg::ST_WHOLE;
              end
            end
            else if (frameShort && wel && cmdNow.op == sfe_pkg::OP_ERASE_PERSIST)
            begin
              if (protReg[sfe_pkg::PROT_GUARD] || protReg[sfe_pkg::PROT_PERM]
                  || protReg[sfe_pkg::PROT_LOCK])
              begin
                failFlag <= 1'b1;
                wel      <= 1'b0;
              end
              else
              begin
                failFlag <= 1'b0;
                timer    <= 16'(PERSIST_CYC - 1);
                state    <= sfe_pkg::ST_PERSIST;
              end
            end
            else if (frameLong && cmdNow.op == sfe_pkg::OP_CHECK_RESULT)
            begin
              timer <= 16'(CHECK_CYC - 1);
              state <= sfe_pkg::ST_CHECK;
            end
            else if (frameLong && cmdNow.op == sfe_pkg::OP_ERASE_COUNT)
            begin
              timer <= 16'(COUNT_CYC - 1);
              state <= sfe_pkg::ST_COUNT;
            end
          end
        end
        sfe_pkg::ST_ERASE:
        begin
          if (go && frameShort && cmdNow.op == sfe_pkg::OP_SUSPEND)
          begin
            suspended <= 1'b1;
            state     <= sfe_pkg::ST_SUSP;
          end
          else if (timerDone)
          begin
            wel   <= 1'b0;
            state <= sfe_pkg::ST_IDLE;
            if (tgtSmall)
            begin
              smDone[tgtSm]  <= 1'b1;
              smDirty[tgtSm] <= smMark[tgtSm];
            end
            else
            begin
              // overlaid small sectors keep their contents
              lgDone[tgtLg]  <= 1'b1;
              lgDirty[tgtLg] <= lgMark[tgtLg];
            end
            if (!skipErase && !tgtSmall)
            begin
              countCorrupt[tgtLg] <= (eraseCount[tgtLg] == 23'h7F_FFFF);
              eraseCount[tgtLg]   <= eraseCount[tgtLg] + 23'h00_0001;
            end
          end
        end
        sfe_pkg::ST_SUSP:
        begin
          if (go && frameShort && cmdNow.op == sfe_pkg::OP_RESUME)
          begin
            suspended <= 1'b0;
            state     <= sfe_pkg::ST_ERASE;
          end
        end
        sfe_pkg::ST_WHOLE:
        begin
          // suspend requests fall through unanswered here
          if (timerDone)
          begin
            wel   <= 1'b0;
            state <= sfe_pkg::ST_IDLE;
            for (int i = 0; i < NSEC; i++)
            begin
              if (!dynProt[i] && persistBits[i])
              begin
                lgDirty[i] <= lgMark[i];
                lgDone[i]  <= 1'b1;
                if (SW'(i) == ovIdx && !uniform)
                begin
                  smDirty <= smMark;
                  smDone  <= 32'hFFFF_FFFF;
                end
              end
            end
          end
        end
        sfe_pkg::ST_PERSIST:
        begin
          if (timerDone)
          begin
            persistBits <= '1;
            wel         <= 1'b0;
            state       <= sfe_pkg::ST_IDLE;
          end
        end
        sfe_pkg::ST_CHECK:
        begin
          if (timerDone)
          begin
            checkRes <= tgtSmall ? smDone[tgtSm] : lgDone[tgtLg];
            state    <= sfe_pkg::ST_IDLE;
          end
        end
        sfe_pkg::ST_COUNT:
        begin
          if (timerDone)
          begin
            countReg <= {countCorrupt[tgtLg], eraseCount[tgtLg]};
            state    <= sfe_pkg::ST_IDLE;
          end
        end
        default:
          state <= sfe_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial read-back
  // ----------------------------------------------------------------
  logic [7:0]  statusOne;
  logic [7:0]  statusTwo;
  logic [31:0] shiftOut;

  always_comb
  begin
    statusOne = 8'h00;
    statusOne[sfe_pkg::SR1_BUSY] = busy;
    statusOne[sfe_pkg::SR1_WEL]  = wel;
    statusOne[sfe_pkg::SR1_FAIL] = failFlag;
    statusTwo = 8'h00;
    statusTwo[sfe_pkg::SR2_SUSP]   = suspended;
    statusTwo[sfe_pkg::SR2_RESULT] = checkRes;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      shiftOut <= 32'h0000_0000;
    else if (sclkFall && !csLvl)
    begin
      if (frameShort && shiftIn[7:0] == sfe_pkg::OP_READ_STATUS_ONE)
        shiftOut <= {statusOne, 24'h00_0000};
      else if (frameShort && shiftIn[7:0] == sfe_pkg::OP_READ_STATUS_TWO)
        shiftOut <= {statusTwo, 24'h00_0000};
      else if (frameLong && shiftIn[39:32] == sfe_pkg::OP_READ_ANY_REG)
        shiftOut <= {8'h00, countReg};
      else
        shiftOut <= {shiftOut[30:0], 1'b0};
    end
  end

  assign spiMiso   = shiftOut[31];
  assign spiMisoOe = !csLvl;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped offsets
  // ----------------------------------------------------------------
  assign pready = 1'b1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      case (paddr)
        sfe_pkg::OFF_CONFIG:  prdata <= cfgReg;
        sfe_pkg::OFF_PROTECT: prdata <= protReg;
        sfe_pkg::OFF_DYNPROT: prdata <= 32'(dynProt);
        sfe_pkg::OFF_PERSIST: prdata <= 32'(persistBits);
        sfe_pkg::OFF_STATUS:  prdata <= {16'h0000, statusTwo, statusOne};
        sfe_pkg::OFF_LGDIRTY: prdata <= 32'(lgDirty);
        sfe_pkg::OFF_SMDIRTY: prdata <= smDirty;
        sfe_pkg::OFF_COUNT:   prdata <= {8'h00, countReg};
        default:
        begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_no_latch_no_erase;
    (state == sfe_pkg::ST_IDLE) && go && !wel && frameLong && cmdNow.op == sfe_pkg::OP_ERASE_LARGE
      |=> (state == sfe_pkg::ST_IDLE) && $stable(failFlag);
  endproperty
  a_no_latch_no_erase: assert property (p_no_latch_no_erase) else $error("erase ran without latch");

  property p_latch_cleared;
    (state == sfe_pkg::ST_ERASE) && timerDone && !(go && frameShort) |=> !wel && !busy;
  endproperty
  a_latch_cleared: assert property (p_latch_cleared) else $error("latch kept after erase");

  property p_busy_during_erase;
    $rose(state == sfe_pkg::ST_ERASE) && !$past(state == sfe_pkg::ST_SUSP) |-> busy [*3];
  endproperty
  a_busy_during_erase: assert property (p_busy_during_erase) else $error("busy low in erase");

  property p_protected_fails;
    (state == sfe_pkg::ST_IDLE) && go && wel && frameLong && protHit
      && cmdNow.op == sfe_pkg::OP_ERASE_LARGE |=> failFlag && !busy && !wel;
  endproperty
  a_protected_fails: assert property (p_protected_fails) else $error("protected erase ran");

  property p_uniform_ignores_small;
    (state == sfe_pkg::ST_IDLE) && go && frameLong && uniform
      && cmdNow.op == sfe_pkg::OP_ERASE_SMALL |=> !busy && $stable(wel) && $stable(failFlag);
  endproperty
  a_uniform_ignores_small: assert property (p_uniform_ignores_small) else $error("small erase ran");

  property p_outside_small_silent;
    (state == sfe_pkg::ST_IDLE) && go && wel && frameLong && !uniform && !inSmall
      && cmdNow.op == sfe_pkg::OP_ERASE_SMALL |=> !busy && $stable(failFlag);
  endproperty
  a_outside_small_silent: assert property (p_outside_small_silent) else $error("bad small abort");

  property p_whole_needs_bp_clear;
    (state == sfe_pkg::ST_IDLE) && go && wel && frameShort && blockProt != 3'h0
      && cmdNow.op == sfe_pkg::OP_ERASE_WHOLE |=> failFlag && (state == sfe_pkg::ST_IDLE);
  endproperty
  a_whole_needs_bp_clear: assert property (p_whole_needs_bp_clear) else $error("whole erase ran");

  property p_check_result;
    (state == sfe_pkg::ST_CHECK) && timerDone && !tgtSmall
      |=> (statusTwo[sfe_pkg::SR2_RESULT] == $past(lgDone[tgtLg])) && !busy;
  endproperty
  a_check_result: assert property (p_check_result) else $error("result bit wrong");

  property p_whole_not_suspended;
    (state == sfe_pkg::ST_WHOLE) && !timerDone |=> (state == sfe_pkg::ST_WHOLE) && !suspended;
  endproperty
  a_whole_not_suspended: assert property (p_whole_not_suspended) else $error("whole erase halted");

  property p_suspend_flag;
    (state == sfe_pkg::ST_ERASE) && go && frameShort && cmdNow.op == sfe_pkg::OP_SUSPEND
      |=> suspended && !busy ##1 !busy;
  endproperty
  a_suspend_flag: assert property (p_suspend_flag) else $error("suspend not shown");

endmodule : sfe_erase_ctrl

//--- sim/sfe_spi_host.sv
// mode-0 SPI host model facing the erase controller's serial port
`timescale 1ns/1ns
module sfe_spi_host (
  input  wire logic clk,
  input  wire logic spiMiso,
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiMosi
);
  initial
  begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end
  // four clk per half period gives 800 ns; the clock stands low between frames
  task automatic xfer(input logic [71:0] tx, input int n, output logic [71:0] rx);
    rx = '0;
    @(posedge clk) spiCsN <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      spiMosi <= tx[i];
      repeat (4) @(posedge clk);
      spiClk <= 1'b1;
      repeat (4) @(posedge clk);
      // miso only moves after a synced fall, so it is still settled here
      rx = {rx[70:0], spiMiso};
      spiClk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spiCsN <= 1'b1;
    spiMosi <= ~tx[0];
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : sfe_spi_host

//--- sim/tb.sv
// self-checking bench for the serial flash erase controller
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        spiClk, spiCsN, spiMosi, spiMiso, spiMisoOe, pready, pslverr, e;
  logic [71:0] rx;
  int          errors = 0;
  int          compares = 0;
  always #50 clk = ~clk;
  sfe_erase_ctrl #(.LARGE_CYC(200), .WHOLE_CYC(200)) i_sfe_erase_ctrl (.clk(clk), .rst(rst),
    .spiClk(spiClk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sfe_spi_host i_sfe_spi_host (.clk(clk), .spiMiso(spiMiso), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiMosi(spiMosi));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input logic [31:0] exp);
    apb(1'b0, sfe_pkg::OFF_STATUS, 32'h0);
    chk(q & 32'h23, exp);
  endtask : st
  // a command of n bits, address after the opcode, idle bits after that
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int n);
    i_sfe_spi_host.xfer({op, a, 32'h0} >> (72 - n), n, rx);
  endtask : cmd
  task automatic idle();
    for (int k = 0; k < 100; k++)
    begin
      apb(1'b0, sfe_pkg::OFF_STATUS, 32'h0);
      if (q[sfe_pkg::SR1_BUSY] === 1'b0) break;
      if (k == 99) errors++;
    end
  endtask : idle
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, sfe_pkg::OFF_CONFIG, 32'h0);
    chk(q, sfe_pkg::CONFIG_RESET);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, spiMisoOe}, 32'h0);
    st(32'h0);
    $display("test reset done");
    cmd(sfe_pkg::OP_ERASE_LARGE, 32'h0004_0000, 40);
    st(32'h0);
    apb(1'b1, sfe_pkg::OFF_DYNPROT, 32'h4);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    st(32'h2);
    cmd(sfe_pkg::OP_ERASE_LARGE, 32'h0008_0000, 40);
    idle();
    st(32'h20);
    $display("test protected done");
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_LARGE, 32'h0004_0000, 40);
    st(32'h3);
    idle();
    st(32'h0);
    $display("test erase done");
    apb(1'b1, sfe_pkg::OFF_CONFIG, 32'h1);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_WHOLE, 32'h0, 8);
    idle();
    st(32'h20);
    apb(1'b1, sfe_pkg::OFF_CONFIG, 32'h8);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_SMALL, 32'h0, 40);
    st(32'h22);
    cmd(sfe_pkg::OP_READ_STATUS_ONE, 32'h0, 16);
    chk({24'h0, rx[7:0] & 8'h23}, 32'h22);
    cmd(sfe_pkg::OP_ERASE_COUNT, 32'h0004_0000, 40);
    idle();
    cmd(sfe_pkg::OP_READ_ANY_REG, 32'h0, 72);
    chk(rx[31:0], 32'h1);
    $display("test serial done");
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_LARGE, 32'h0004_0000, 40);
    cmd(sfe_pkg::OP_SUSPEND, 32'h0, 8);
    idle();
    apb(1'b0, sfe_pkg::OFF_STATUS, 32'h0);
    chk(q & 32'h623, 32'h202);
    cmd(sfe_pkg::OP_RESUME, 32'h0, 8);
    st(32'h3);
    idle();
    st(32'h0);
    cmd(sfe_pkg::OP_CHECK_RESULT, 32'h0004_0000, 40);
    idle();
    apb(1'b0, sfe_pkg::OFF_STATUS, 32'h0);
    chk(q & 32'h623, 32'h400);
    if (q[10] !== 1'b1)
    begin
      cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
      cmd(sfe_pkg::OP_ERASE_LARGE, 32'h0004_0000, 40);
      idle();
    end
    apb(1'b1, sfe_pkg::OFF_LGDIRTY, 32'h6);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_WHOLE, 32'h0, 8);
    cmd(sfe_pkg::OP_SUSPEND, 32'h0, 8);
    st(32'h3);
    idle();
    apb(1'b0, sfe_pkg::OFF_STATUS, 32'h0);
    chk(q & 32'h623, 32'h400);
    apb(1'b0, sfe_pkg::OFF_LGDIRTY, 32'h0);
    chk(q, 32'h4);
    $display("test suspend done");
    apb(1'b1, sfe_pkg::OFF_CONFIG, 32'h0);
    apb(1'b1, sfe_pkg::OFF_SMDIRTY, 32'h2);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_SMALL, 32'h0000_1000, 40);
    idle();
    apb(1'b0, sfe_pkg::OFF_SMDIRTY, 32'h0);
    chk(q, 32'h0);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_SMALL, 32'h0004_0000, 40);
    st(32'h0);
    apb(1'b1, sfe_pkg::OFF_PROTECT, 32'h100);
    cmd(sfe_pkg::OP_SET_WRITE_LATCH, 32'h0, 8);
    cmd(sfe_pkg::OP_ERASE_PERSIST, 32'h0, 8);
    st(32'h20);
    $display("test hybrid done");
    test_done();
  end
  initial
  begin
    #3000000;
    errors++;
    test_done();
  end
endmodule : tb
